// ### pkg/bcta_cfg.svh
`ifndef BCTA_CFG_SVH
`define BCTA_CFG_SVH

// Register byte offsets
`define BCTA_OFF_RX_IO      8'h00
`define BCTA_OFF_TX_IO      8'h04
`define BCTA_OFF_RX_ES      8'h08
`define BCTA_OFF_TX_ES      8'h0c
`define BCTA_OFF_BP_CFG     8'h10
`define BCTA_OFF_STATUS     8'h14
`define BCTA_OFF_RX_BLK     8'h20
`define BCTA_OFF_TX_BLK     8'h30
`define BCTA_OFF_RX_GAP     8'h40
`define BCTA_OFF_TX_GAP     8'h50

// Field positions
`define BCTA_BIT_CT_SYNC_EN 5
`define BCTA_BIT_SYNC_INV   1
`define BCTA_BIT_TX_SYNC_IN 0
`define BCTA_BIT_GAP_EN     6
`define BCTA_BIT_FMT56      7
`define BCTA_BIT_T1_BP      0
`define BCTA_BIT_IBO4       1
`define BCTA_BIT_EVEN_PORT  2

// Reset values
`define BCTA_RST_BYTE       8'h00
`define BCTA_RST_MASK       32'h0000_0000

// Frame timing in backplane bit times (last bit index)
`define BCTA_T1_LAST_BIT    9'd192
`define BCTA_E1_LAST_BIT    9'd255
`define BCTA_DC_BIT_POS     3'd7

`endif

// ### pkg/bcta_pkg.sv
package bcta_pkg;
    typedef logic [7:0]  bcta_byte_t;
    typedef logic [31:0] bcta_chmask_t;
    typedef logic [8:0]  bcta_bitcnt_t;
    typedef enum logic { BCTA_SAMPLE_FALL, BCTA_SAMPLE_RISE } bcta_sample_t;
endpackage

// ### pkg/bcta_path_if.sv
`timescale 1ns/1ps
interface bcta_path_if;
    import bcta_pkg::*;
    logic         bitTick;
    logic         bpDly;
    logic         frameMark;
    logic         t1Mode;
    logic         gapEn;
    logic         fmt56;
    bcta_chmask_t blockSel;
    bcta_chmask_t gapSel;
    logic         chBlock;
    logic         chClk;
    bcta_bitcnt_t bitCnt;
    modport ctrl (output bitTick, bpDly, frameMark, t1Mode, gapEn, fmt56, blockSel, gapSel,
                  input chBlock, chClk, bitCnt);
    modport gen  (input bitTick, bpDly, frameMark, t1Mode, gapEn, fmt56, blockSel, gapSel,
                  output chBlock, chClk, bitCnt);
endinterface

// ### rtl/bcta_sync_sampler.sv
`timescale 1ns/1ps
`include "bcta_cfg.svh"
module bcta_sync_sampler import bcta_pkg::*; (
    input  wire logic clk,       // System clock
    input  wire logic sys_rst,   // Synchronous reset
    input  wire logic syncLvl,   // Synchronised frame-sync level
    input  wire logic riseTick,  // Backplane clock rising edge
    input  wire logic fallTick,  // Backplane clock falling edge
    input  wire logic ctEn,      // CT-bus sampling point
    input  wire logic invert,    // Inbound sync inverted
    output logic      frameMark  // One-cycle frame start mark
);
    bcta_sample_t edgeSel;
    logic         sampled;
    logic         hit;
    logic         last_q, last_d;
    logic         mark_d;

    // Pick the sampling edge, then apply polarity separately
    always_comb begin
        edgeSel = ctEn ? BCTA_SAMPLE_RISE : BCTA_SAMPLE_FALL;
        hit     = (edgeSel == BCTA_SAMPLE_RISE) ? riseTick : fallTick;
        sampled = syncLvl ^ invert;
        last_d  = hit ? sampled : last_q;
        mark_d  = hit & sampled & ~last_q;
    end

    // Register sampled level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            last_q <= 1'b0;
        end else begin
            last_q <= last_d;
        end
    end

    // Mark leaves unregistered so a rising-edge sample meets its own bit tick
    assign frameMark = mark_d;
endmodule

// ### rtl/bcta_chan_gen.sv
`timescale 1ns/1ps
`include "bcta_cfg.svh"
module bcta_chan_gen import bcta_pkg::*; (
    input  wire logic clk,     // System clock
    input  wire logic sys_rst, // Synchronous reset
    bcta_path_if.gen  p        // Path timing and outputs
);
    bcta_bitcnt_t cnt_q, cnt_d;
    logic         pend_q, pend_d;
    logic         blk_q, blk_d;
    logic         chc_q, chc_d;
    bcta_bitcnt_t lastBit;
    bcta_bitcnt_t slotBits;
    logic [4:0]   chan;
    logic [2:0]   bitPos;
    logic         inSlot;

    // Bit counter locked to the frame mark
    always_comb begin
        lastBit = p.t1Mode ? `BCTA_T1_LAST_BIT : `BCTA_E1_LAST_BIT;
        pend_d  = pend_q | p.frameMark;
        cnt_d   = cnt_q;
        if (p.bitTick) begin
            if (pend_q | p.frameMark) begin
                cnt_d  = '0;
                pend_d = 1'b0;
            end else if (cnt_q == lastBit) begin
                cnt_d = '0;
            end else begin
                cnt_d = cnt_q + 9'd1;
            end
        end
    end

    // Channel decode and output gating
    always_comb begin
        slotBits = p.t1Mode ? (cnt_q - 9'd1) : cnt_q;           // T1 bit 0 is the F bit
        inSlot   = ~(p.t1Mode & (cnt_q == 9'd0));
        chan     = slotBits[7:3];
        bitPos   = slotBits[2:0];
        blk_d    = inSlot & p.blockSel[chan];
        chc_d    = p.bpDly & inSlot & p.gapEn & p.gapSel[chan]
                 & ~(p.fmt56 & (bitPos == `BCTA_DC_BIT_POS));
    end

    // State registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q  <= '0;
            pend_q <= 1'b0;
            blk_q  <= 1'b0;
            chc_q  <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            pend_q <= pend_d;
            blk_q  <= blk_d;
            chc_q  <= chc_d;
        end
    end

    assign p.chBlock = blk_q;
    assign p.chClk   = chc_q;
    assign p.bitCnt  = cnt_q;
endmodule

// ### rtl/bcta_top.sv
`timescale 1ns/1ps
`include "bcta_cfg.svh"
module bcta_top import bcta_pkg::*; (
    input  wire logic        clk,           // System clock, 250 MHz
    input  wire logic        sys_rst,       // Synchronous reset, active high
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB enable
    input  wire logic        pwrite,        // APB direction
    input  wire logic [7:0]  paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    input  wire logic [3:0]  pstrb,         // APB byte strobes
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    input  wire logic        bpClkPin,      // Backplane clock
    input  wire logic        rxSyncPin,     // Receive frame sync, own port
    input  wire logic        rxSyncPairPin, // Receive frame sync of odd neighbour
    input  wire logic        txSyncPinIn,   // Transmit frame sync pin, input side
    output logic             txSyncPinOut,  // Transmit frame sync pin, output side
    output logic             txSyncPinOe,   // Transmit frame sync pin drive enable
    output logic             rxChanBlock,   // Receive channel block output
    output logic             txChanBlock,   // Transmit channel block output
    output logic             rxChanClk,     // Receive gapped channel clock
    output logic             txChanClk      // Transmit gapped channel clock
);
    // Configuration registers
    bcta_byte_t   rxIo_q, rxIo_d;
    bcta_byte_t   txIo_q, txIo_d;
    bcta_byte_t   rxEs_q, rxEs_d;
    bcta_byte_t   txEs_q, txEs_d;
    bcta_byte_t   bpCfg_q, bpCfg_d;
    bcta_chmask_t rxBlk_q, rxBlk_d;
    bcta_chmask_t txBlk_q, txBlk_d;
    bcta_chmask_t rxGap_q, rxGap_d;
    bcta_chmask_t txGap_q, txGap_d;

    // Bus answer registers
    logic [31:0]  rdata_q, rdata_d;
    logic         ready_q, ready_d;
    logic         err_q, err_d;

    // Pin synchronisers
    logic [3:0]   meta_q;
    logic [3:0]   sync_q;
    logic         bpDly_q;

    // Transmit sync pin drive
    logic         tsOut_q, tsOut_d;
    logic         tsOe_q, tsOe_d;

    // Decode helpers
    logic         setup;
    logic         access;
    logic         mapped;
    logic [7:0]   grpBase;
    logic [4:0]   lanePos;
    logic [31:0]  rdMux;
    bcta_byte_t   wByte;
    logic         wrEn;

    // Derived timing
    logic         riseTick;
    logic         fallTick;
    logic         rxSyncSel;
    logic         rxMark;
    logic         txMark;
    logic         ctEn;
    logic         txInMode;

    bcta_path_if rxPath ();
    bcta_path_if txPath ();

    // Two-stage synchronisers, third stage on the clock pin for edges
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q  <= 4'h0;
            sync_q  <= 4'h0;
            bpDly_q <= 1'b0;
        end else begin
            meta_q  <= {txSyncPinIn, rxSyncPairPin, rxSyncPin, bpClkPin};
            sync_q  <= meta_q;
            bpDly_q <= sync_q[0];
        end
    end

    // Backplane clock edges and sync source choice
    always_comb begin
        riseTick  = sync_q[0] & ~bpDly_q;
        fallTick  = ~sync_q[0] & bpDly_q;
        ctEn      = rxIo_q[`BCTA_BIT_CT_SYNC_EN];
        txInMode  = txIo_q[`BCTA_BIT_TX_SYNC_IN];
        rxSyncSel = (bpCfg_q[`BCTA_BIT_IBO4] & bpCfg_q[`BCTA_BIT_EVEN_PORT])
                  ? sync_q[2] : sync_q[1];
    end

    // Receive frame sync sampling
    bcta_sync_sampler u_rx_sync (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .syncLvl   (rxSyncSel),
        .riseTick  (riseTick),
        .fallTick  (fallTick),
        .ctEn      (ctEn),
        .invert    (rxIo_q[`BCTA_BIT_SYNC_INV]),
        .frameMark (rxMark)
    );

    // Transmit frame sync sampling, same CT-bus enable
    bcta_sync_sampler u_tx_sync (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .syncLvl   (sync_q[3]),
        .riseTick  (riseTick),
        .fallTick  (fallTick),
        .ctEn      (ctEn),
        .invert    (txIo_q[`BCTA_BIT_SYNC_INV]),
        .frameMark (txMark)
    );

    // Receive path control
    assign rxPath.bitTick   = riseTick;
    assign rxPath.bpDly     = bpDly_q;
    assign rxPath.frameMark = rxMark;
    assign rxPath.t1Mode    = bpCfg_q[`BCTA_BIT_T1_BP];
    assign rxPath.gapEn     = rxEs_q[`BCTA_BIT_GAP_EN];
    assign rxPath.fmt56     = rxEs_q[`BCTA_BIT_FMT56];
    assign rxPath.blockSel  = rxBlk_q;
    assign rxPath.gapSel    = rxGap_q;

    // Transmit path control; sync only counts in input mode
    assign txPath.bitTick   = riseTick;
    assign txPath.bpDly     = bpDly_q;
    assign txPath.frameMark = txMark & txInMode;
    assign txPath.t1Mode    = bpCfg_q[`BCTA_BIT_T1_BP];
    assign txPath.gapEn     = txEs_q[`BCTA_BIT_GAP_EN];
    assign txPath.fmt56     = txEs_q[`BCTA_BIT_FMT56];
    assign txPath.blockSel  = txBlk_q;
    assign txPath.gapSel    = txGap_q;

    bcta_chan_gen u_rx_gen (
        .clk     (clk),
        .sys_rst (sys_rst),
        .p       (rxPath)
    );

    bcta_chan_gen u_tx_gen (
        .clk     (clk),
        .sys_rst (sys_rst),
        .p       (txPath)
    );

    // Transmit sync pin: driven frame pulse in output mode, unaffected by CT-bus
    always_comb begin
        tsOe_d  = ~txInMode;
        tsOut_d = ~txInMode & (txPath.bitCnt == 9'd0);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tsOut_q <= 1'b0;
            tsOe_q  <= 1'b0;
        end else begin
            tsOut_q <= tsOut_d;
            tsOe_q  <= tsOe_d;
        end
    end

    // Address decode and read mux
    always_comb begin
        setup   = psel & ~penable;
        access  = psel & penable & ready_q;
        grpBase = {paddr[7:4], 4'h0};
        lanePos = {paddr[3:2], 3'b000};
        wByte   = pwdata[7:0];
        rdMux   = 32'h0000_0000;
        mapped  = 1'b1;
        if (paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end else if (paddr == `BCTA_OFF_RX_IO) begin
            rdMux = {24'h000000, rxIo_q};
        end else if (paddr == `BCTA_OFF_TX_IO) begin
            rdMux = {24'h000000, txIo_q};
        end else if (paddr == `BCTA_OFF_RX_ES) begin
            rdMux = {24'h000000, rxEs_q};
        end else if (paddr == `BCTA_OFF_TX_ES) begin
            rdMux = {24'h000000, txEs_q};
        end else if (paddr == `BCTA_OFF_BP_CFG) begin
            rdMux = {24'h000000, bpCfg_q};
        end else if (paddr == `BCTA_OFF_STATUS) begin
            rdMux = {7'h00, txPath.bitCnt, 7'h00, rxPath.bitCnt};
        end else if (grpBase == `BCTA_OFF_RX_BLK) begin
            rdMux = {24'h000000, rxBlk_q[lanePos +: 8]};
        end else if (grpBase == `BCTA_OFF_TX_BLK) begin
            rdMux = {24'h000000, txBlk_q[lanePos +: 8]};
        end else if (grpBase == `BCTA_OFF_RX_GAP) begin
            rdMux = {24'h000000, rxGap_q[lanePos +: 8]};
        end else if (grpBase == `BCTA_OFF_TX_GAP) begin
            rdMux = {24'h000000, txGap_q[lanePos +: 8]};
        end else begin
            mapped = 1'b0;
        end
        wrEn = access & pwrite & mapped & pstrb[0];
    end

    // Bus answer: one access cycle, data and error prepared in setup
    always_comb begin
        ready_d = setup;
        err_d   = setup & ~mapped;
        rdata_d = (setup & ~pwrite) ? rdMux : 32'h0000_0000;
    end

    // Register writes into the low byte lane
    always_comb begin
        rxIo_d  = rxIo_q;
        txIo_d  = txIo_q;
        rxEs_d  = rxEs_q;
        txEs_d  = txEs_q;
        bpCfg_d = bpCfg_q;
        rxBlk_d = rxBlk_q;
        txBlk_d = txBlk_q;
        rxGap_d = rxGap_q;
        txGap_d = txGap_q;
        if (wrEn) begin
            if (paddr == `BCTA_OFF_RX_IO) begin
                rxIo_d = wByte;
            end else if (paddr == `BCTA_OFF_TX_IO) begin
                txIo_d = wByte;
            end else if (paddr == `BCTA_OFF_RX_ES) begin
                rxEs_d = wByte;
            end else if (paddr == `BCTA_OFF_TX_ES) begin
                txEs_d = wByte;
            end else if (paddr == `BCTA_OFF_BP_CFG) begin
                bpCfg_d = wByte;
            end else if (grpBase == `BCTA_OFF_RX_BLK) begin
                rxBlk_d[lanePos +: 8] = wByte;
            end else if (grpBase == `BCTA_OFF_TX_BLK) begin
                txBlk_d[lanePos +: 8] = wByte;
            end else if (grpBase == `BCTA_OFF_RX_GAP) begin
                rxGap_d[lanePos +: 8] = wByte;
            end else if (grpBase == `BCTA_OFF_TX_GAP) begin
                txGap_d[lanePos +: 8] = wByte;
            end
        end
    end

    // Register file and bus answer flops
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxIo_q  <= `BCTA_RST_BYTE;
            txIo_q  <= `BCTA_RST_BYTE;
            rxEs_q  <= `BCTA_RST_BYTE;
            txEs_q  <= `BCTA_RST_BYTE;
            bpCfg_q <= `BCTA_RST_BYTE;
            rxBlk_q <= `BCTA_RST_MASK;
            txBlk_q <= `BCTA_RST_MASK;
            rxGap_q <= `BCTA_RST_MASK;
            txGap_q <= `BCTA_RST_MASK;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            rxIo_q  <= rxIo_d;
            txIo_q  <= txIo_d;
            rxEs_q  <= rxEs_d;
            txEs_q  <= txEs_d;
            bpCfg_q <= bpCfg_d;
            rxBlk_q <= rxBlk_d;
            txBlk_q <= txBlk_d;
            rxGap_q <= rxGap_d;
            txGap_q <= txGap_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q   <= err_d;
        end
    end

    // Outputs, all from flops
    assign prdata       = rdata_q;
    assign pready       = ready_q;
    assign pslverr      = err_q;
    assign txSyncPinOut = tsOut_q;
    assign txSyncPinOe  = tsOe_q;
    assign rxChanBlock  = rxPath.chBlock;
    assign txChanBlock  = txPath.chBlock;
    assign rxChanClk    = rxPath.chClk;
    assign txChanClk    = txPath.chClk;
endmodule

// ### dv/bcta_top_asserts.sv
`timescale 1ns/1ps
module bcta_top_asserts import bcta_pkg::*; (
    input wire logic        clk,         // System clock
    input wire logic        sys_rst,     // Synchronous reset
    input wire logic        psel,        // APB select
    input wire logic        penable,     // APB enable
    input wire logic        pwrite,      // APB direction
    input wire logic [7:0]  paddr,       // APB address
    input wire logic [31:0] pwdata,      // APB write data
    input wire logic [3:0]  pstrb,       // APB strobes
    input wire logic [31:0] prdata,      // APB read data
    input wire logic        pready,      // APB ready
    input wire logic        pslverr,     // APB error
    input wire logic        bpClkPin,    // Backplane clock
    input wire logic        txSyncPinOe, // Sync pin drive
    input wire logic        rxChanBlock, // Receive block
    input wire logic        txChanBlock, // Transmit block
    input wire logic        rxChanClk,   // Receive gapped clock
    input wire logic        txChanClk    // Transmit gapped clock
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] bpHist_q, bpHist_d;
    logic [3:0] riseAge_q, riseAge_d;
    logic       txIn_q, txIn_d;
    logic [1:0] wrAge_q, wrAge_d;
    // Age of the last backplane rising edge, sync direction shadow, cycles since a write
    always_comb begin
        bpHist_d = {bpHist_q[6:0], bpClkPin};
        riseAge_d = (riseAge_q == 4'hf) ? riseAge_q : riseAge_q + 4'h1;
        if (bpHist_q[0] && !bpHist_q[1]) riseAge_d = 4'h0;
        txIn_d = txIn_q;
        if (psel && penable && pready && pwrite && paddr == 8'h04 && pstrb[0]) txIn_d = pwdata[0];
        wrAge_d = (wrAge_q == 2'h3) ? wrAge_q : wrAge_q + 2'h1;
        if (psel && penable && pready && pwrite) wrAge_d = 2'h0;
        if (sys_rst) begin
            riseAge_d = 4'hf;
            txIn_d = 1'b0;
            wrAge_d = 2'h3;
        end
    end
    // Helper registers
    always_ff @(posedge clk) begin
        bpHist_q <= bpHist_d;
        riseAge_q <= riseAge_d;
        txIn_q <= txIn_d;
        wrAge_q <= wrAge_d;
    end
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_misaligned: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_rx_blk_timing: assert property (wrAge_q == 2'h3 && $changed(rxChanBlock) |->
        riseAge_q inside {[1:8]})
        else $error("receive block moved mid-bit");
    a_tx_blk_timing: assert property (wrAge_q == 2'h3 && $changed(txChanBlock) |->
        riseAge_q inside {[1:8]})
        else $error("transmit block moved mid-bit");
    a_rx_gap_bp: assert property (rxChanClk |-> |bpHist_q)
        else $error("receive gapped clock without backplane clock");
    a_tx_gap_bp: assert property (txChanClk |-> |bpHist_q)
        else $error("transmit gapped clock without backplane clock");
    a_gap_rise_timing: assert property (wrAge_q == 2'h3 &&
        ($rose(rxChanClk) || $rose(txChanClk)) |-> riseAge_q <= 4'h8)
        else $error("gapped clock pulse off the bit edge");
    a_tx_pin_released: assert property (txIn_q && $past(txIn_q, 2) |-> !txSyncPinOe)
        else $error("sync pin driven in input mode");
    c_rx_gap: cover property ($rose(rxChanClk));
    c_tx_blk: cover property ($rose(txChanBlock));
    c_refused: cover property (pslverr);
endmodule
bind bcta_top bcta_top_asserts u_asserts (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .bpClkPin, .txSyncPinOe, .rxChanBlock,
    .txChanBlock, .rxChanClk, .txChanClk);

// ### dv/bcta_bp_model.sv
`timescale 1ns/1ps
module bcta_bp_model import bcta_pkg::*; (
    input  wire logic    t1,       // 193-bit frame, else 256
    input  wire logic    ct,       // Pulse on a rising edge
    input  wire logic    inv,      // Sync active low
    input  wire logic    skew,     // Own sync 100 bits off
    output logic         bpClk,    // Backplane clock, 80 ns
    output logic         rxSync,   // Own receive sync
    output logic         pairSync, // Odd neighbour sync
    output logic         txSync,   // Transmit sync
    output bcta_bitcnt_t bitIdx    // Bit now on the bus
);
    // Pulse around the last falling edge, or the rising edge of bit 0
    function automatic logic pulse(input int b, input int s, input int n);
        if (ct) return (b == n - 1 && s == 7) || (b == 0 && s < 2);
        return b == n - 1 && s >= 3 && s <= 5;
    endfunction
    // Free-running clock in 10 ns steps
    initial begin
        int k;
        int n;
        k = 0;
        {bpClk, rxSync, pairSync, txSync, bitIdx} = '0;
        #1;
        forever begin
            n = t1 ? 193 : 256;
            k = k % n;
            bitIdx = 9'(k);
            for (int s = 0; s < 8; s++) begin
                bpClk = s < 4;
                pairSync = pulse(k, s, n) ^ inv;
                txSync = pairSync;
                rxSync = pulse(skew ? (k + 100) % n : k, s, n) ^ inv;
                #10;
            end
            k = k + 1;
        end
    end
endmodule

// ### dv/bcta_top_tb.sv
`timescale 1ns/1ps
module bcta_top_tb;
    import bcta_pkg::*;
    logic         clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, seed, rdq;
    logic [3:0]   pstrb;
    logic         bpClkPin, rxSyncPin, rxSyncPairPin, txSyncPinIn, txSyncPinOut, txSyncPinOe;
    logic         rxChanBlock, txChanBlock, rxChanClk, txChanClk, txDrv;
    logic         t1, ct, inv, skew, mon, f56r, f56t, ger, get;
    bcta_chmask_t rbm, tbm, rgm, tgm;
    bcta_bitcnt_t bitIdx;
    int           n_errors, checked;
    // Sync wire: design drives in output mode, backplane otherwise
    assign txSyncPinIn = txSyncPinOe ? txSyncPinOut : txDrv;
    bcta_top dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .bpClkPin, .rxSyncPin, .rxSyncPairPin, .txSyncPinIn, .txSyncPinOut,
        .txSyncPinOe, .rxChanBlock, .txChanBlock, .rxChanClk, .txChanClk);
    bcta_bp_model bp (.t1, .ct, .inv, .skew, .bpClk(bpClkPin), .rxSync(rxSyncPin),
        .pairSync(rxSyncPairPin), .txSync(txDrv), .bitIdx);
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected output level for a frame bit
    function automatic logic expv(input bcta_bitcnt_t b, input bcta_chmask_t m, input logic f);
        int p;
        p = t1 ? int'(b) - 1 : int'(b);
        if (p < 0) return 1'b0;
        return m[p / 8] && !(f && p % 8 == 7);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer, entered right after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, xr,
                       input logic xe);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // Wait states end only on ready; the watchdog bounds a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdq = prdata;
        chk(32'(pslverr), 32'(xe));
        if (!w && a != 8'h14) chk(rdq, xr);
        {psel, penable} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, d);
        apb(1'b1, a, {24'h0, d}, 32'h0, 1'b0);
    endtask
    task automatic wmask(input logic [7:0] base, input bcta_chmask_t m);
        for (int i = 0; i < 4; i++) begin
            wr(base + 8'(4 * i), m[8 * i +: 8]);
            apb(1'b0, base + 8'(4 * i), 32'h0, {24'h0, m[8 * i +: 8]}, 1'b0);
        end
    endtask
    task automatic frame();
        do @(posedge bpClkPin); while (bitIdx != 0);
    endtask
    // Bit counters read mid-bit against the backplane position
    task automatic status();
        bcta_bitcnt_t b;
        @(negedge bpClkPin);
        @(posedge clk);
        b = bitIdx;
        apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b0);
        chk({23'h0, rdq[8:0]}, {23'h0, b});
        chk({23'h0, rdq[24:16]}, {23'h0, b});
    endtask
    // Output-mode sync pin: one pulse per 256-bit frame, pin driven
    task automatic outsync();
        int n;
        n = 0;
        @(negedge txSyncPinOut);
        do begin
            @(negedge bpClkPin);
            n++;
        end while (txSyncPinOut !== 1'b1);
        chk(32'(n), 32'h100);
        chk(32'(txSyncPinOe), 32'h1);
        @(posedge clk);
    endtask
    task automatic scen(input logic [7:0] rio, tio, res, tes, bpc, input logic sk);
        mon = 1'b0;
        {t1, ct, inv, skew} = {bpc[0], rio[5], rio[1], sk};
        {f56r, ger, f56t, get} = {res[7:6], tes[7:6]};
        {rbm, tbm, rgm, tgm} = {rnd(), rnd(), rnd(), rnd()};
        wr(8'h10, bpc);
        wr(8'h00, rio);
        wr(8'h04, tio);
        wr(8'h08, res);
        wr(8'h0c, tes);
        wmask(8'h20, rbm);
        wmask(8'h30, tbm);
        wmask(8'h40, rgm);
        wmask(8'h50, tgm);
        repeat (2) frame();
        mon = 1'b1;
        status();
        frame();
        status();
        mon = 1'b0;
        $display("test done: cfg %h %h %h %h %h", rio, tio, res, tes, bpc);
    endtask
    // Mid-bit check of the four channel outputs
    always begin
        @(negedge bpClkPin);
        #8;
        if (mon) begin
            chk(32'(rxChanBlock), 32'(expv(bitIdx, rbm, 1'b0)));
            chk(32'(txChanBlock), 32'(expv(bitIdx, tbm, 1'b0)));
            chk(32'(rxChanClk), 32'(ger && expv(bitIdx, rgm, f56r)));
            chk(32'(txChanClk), 32'(get && expv(bitIdx, tgm, f56t)));
        end
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        complete_run();
    end
    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 40'h0, 4'hf};
        {t1, ct, inv, skew, mon} = 5'h0;
        n_errors = 0;
        checked = 0;
        seed = 32'h3940c063;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        // Reset values, refused addresses and a write without strobe
        for (int a = 0; a < 96; a += 4)
            if (a < 20 || a > 28) apb(1'b0, 8'(a), 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h22, 32'hff, 32'h0, 1'b1);
        pstrb <= 4'h0;
        apb(1'b1, 8'h20, 32'hff, 32'h0, 1'b0);
        pstrb <= 4'hf;
        apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b0);
        $display("test done: registers");
        outsync();
        $display("test done: output sync");
        scen(8'h00, 8'h01, 8'h40, 8'h40, 8'h00, 1'b0);
        scen(8'h22, 8'h03, 8'hc0, 8'hc0, 8'h00, 1'b0);
        scen(8'h00, 8'h01, 8'h80, 8'hc0, 8'h07, 1'b1);
        complete_run();
    end
endmodule
